/* File: core/cfl_pkg.sv */
package cfl_pkg;

  // word addresses of the configuration memory, in load order
  localparam int CFL_NUM_WORDS = 8;
  localparam logic [7:0] CFL_WADDR_P0_LINK = 8'h40;
  localparam logic [7:0] CFL_WADDR_P1_LINK = 8'h42;
  localparam logic [7:0] CFL_WADDR_P2_LINK = 8'h44;
  localparam logic [7:0] CFL_WADDR_P3_LINK = 8'h46;
  localparam logic [7:0] CFL_WADDR_P0_PMCAP = 8'h50;
  localparam logic [7:0] CFL_WADDR_P0_PMDATA = 8'h51;
  localparam logic [7:0] CFL_WADDR_P1_PMCAP = 8'h52;
  localparam logic [7:0] CFL_WADDR_P1_PMDATA = 8'h53;

  // configuration space offsets, per port
  localparam logic [7:0] CFL_OFF_PMCAP = 8'h40;
  localparam logic [7:0] CFL_OFF_PMCSR = 8'h44;
  localparam logic [7:0] CFL_OFF_LINKCTL = 8'h78;
  localparam logic [7:0] CFL_OFF_PHY2 = 8'h7C;
  localparam logic [7:0] CFL_OFF_MACCTL = 8'h8C;
  localparam logic [7:0] CFL_OFF_PHY3 = 8'h90;
  localparam logic [7:0] CFL_OFF_DEEMPH = 8'hF0;

  // loader registers, selected by the top address bit
  localparam logic [7:0] CFL_OFF_CTRL = 8'h00;
  localparam logic [7:0] CFL_OFF_STATUS = 8'h04;
  localparam int CFL_CTRL_RELOAD_BIT = 0;
  localparam int CFL_STAT_DONE_BIT = 0;
  localparam int CFL_STAT_BUSY_BIT = 1;
  localparam int CFL_STAT_LOADED_LSB = 8;
  localparam int CFL_STAT_ABSENT_LSB = 12;

  // field positions inside a link word
  localparam int CFL_W_PHY2_LSB = 0;
  localparam int CFL_W_PHY3_LSB = 5;
  localparam int CFL_W_DEEMPH_BIT = 12;
  localparam int CFL_W_COMPL_BIT = 13;
  localparam int CFL_W_DCC_LSB = 14;
  // field positions inside the power-management capability and data words
  localparam int CFL_W_NOSR_BIT = 0;
  localparam int CFL_W_AUX_LSB = 1;
  localparam int CFL_W_D1_BIT = 4;
  localparam int CFL_W_D2_BIT = 5;
  localparam int CFL_W_PME_LSB = 6;
  localparam int CFL_W_PMDATA_LSB = 8;

  // field positions inside configuration dwords
  localparam int CFL_C_PHY2_LSB = 8;
  localparam int CFL_C_DCC_LSB = 8;
  localparam int CFL_C_PHY3_LSB = 0;
  localparam int CFL_C_DEEMPH_BIT = 6;
  localparam int CFL_C_COMPL_BIT = 11;
  localparam int CFL_C_NOSR_BIT = 3;
  localparam int CFL_C_AUX_LSB = 22;
  localparam int CFL_C_D1_BIT = 25;
  localparam int CFL_C_D2_BIT = 26;
  localparam int CFL_C_PME_LSB = 28;
  localparam int CFL_C_PMDATA_LSB = 24;

  // fields held for one port
  typedef struct packed {
    logic [4:0] phy2;
    logic [6:0] phy3;
    logic deemph;
    logic compl_det;
    logic [1:0] dcc_sel;
    logic no_soft_reset;
    logic [2:0] aux_current;
    logic d1_support;
    logic d2_support;
    logic [1:0] pme_support;
    logic [7:0] pm_data;
  } cfl_port_fields_type;

  localparam cfl_port_fields_type CFL_FIELDS_RESET = '0;

  // word read answer from the memory engine
  typedef struct packed {
    logic valid;
    logic absent;
    logic [15:0] data;
  } cfl_mem_rsp_type;

  typedef struct packed {
    logic [10:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cfl_bus_req_type;

endpackage : cfl_pkg

/* File: core/cfl_port_fields.sv */
`timescale 1ns/1ps
`default_nettype none

module cfl_port_fields #(
  parameter bit PM_EN = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic load_link_in,
  input wire logic load_pmcap_in,
  input wire logic load_pmdata_in,
  input wire logic [15:0] word_in,
  output var cfl_pkg::cfl_port_fields_type fields_out
);
  import cfl_pkg::*;

  typedef struct packed {
    cfl_port_fields_type f;
  } cfl_pf_state_type;

  cfl_pf_state_type st_r;
  cfl_pf_state_type st_nxt;

  // scatter each word into its fields; ports without power words keep reset
  always_comb
  begin
    st_nxt = st_r;
    if (load_link_in)
    begin
      st_nxt.f.phy2 = word_in[CFL_W_PHY2_LSB +: 5];
      st_nxt.f.phy3 = word_in[CFL_W_PHY3_LSB +: 7];
      st_nxt.f.deemph = word_in[CFL_W_DEEMPH_BIT];
      st_nxt.f.compl_det = word_in[CFL_W_COMPL_BIT];
      st_nxt.f.dcc_sel = word_in[CFL_W_DCC_LSB +: 2];
    end
    if (PM_EN && load_pmcap_in)
    begin
      st_nxt.f.no_soft_reset = word_in[CFL_W_NOSR_BIT];
      st_nxt.f.aux_current = word_in[CFL_W_AUX_LSB +: 3];
      st_nxt.f.d1_support = word_in[CFL_W_D1_BIT];
      st_nxt.f.d2_support = word_in[CFL_W_D2_BIT];
      st_nxt.f.pme_support = word_in[CFL_W_PME_LSB +: 2];
    end
    if (PM_EN && load_pmdata_in)
    begin
      st_nxt.f.pm_data = word_in[CFL_W_PMDATA_LSB +: 8];
    end
  end

  // field storage
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      st_r <= '{f: CFL_FIELDS_RESET};
    else
      st_r <= st_nxt;
  end

  assign fields_out = st_r.f;

endmodule : cfl_port_fields

`default_nettype wire

/* File: core/cfl_config_loader.sv */
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - word 40h bits 4:0 to port0 7Ch[12:8]
// - word 40h bits 15:14 to port0 8Ch[9:8]
// - word 42h bits 4:0 to port1 7Ch[12:8]
// - word 42h bits 11:5 to port1 90h[6:0]
// - word 42h bit 12 to port1 F0h[6]
// - word 42h bit 13 to port1 78h[11]
// - word 44h same layout, port 2
// - word 46h same layout, port 3
// - word 50h: no-reset 44h[3], aux 40h[24:22]
// - capability bit 4 read-only at 40h[25]
// - capability bit 5 read-only at 40h[26]
// - capability bits 7:6 to 40h[29:28]
// - word 51h high byte to 44h[31:24]
// - words 52h/53h same mapping for port 1
module cfl_config_loader (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [10:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [31:0] bus_rdata_out,
  output logic mem_req_out,
  output logic [7:0] mem_addr_out,
  input wire cfl_pkg::cfl_mem_rsp_type mem_rsp_in,
  output logic load_done_out
);
  import cfl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT = 3'b100
  } cfl_state_type;

  typedef struct packed {
    cfl_state_type state;
    logic [2:0] idx;
    logic req;
    logic [7:0] addr;
    logic done;
    logic reload_pend;
    logic [3:0] loaded_cnt;
    logic [3:0] absent_cnt;
    logic [31:0] rdata;
  } cfl_ld_state_type;

  localparam logic [2:0] LAST_IDX = 3'(CFL_NUM_WORDS - 1);

  cfl_ld_state_type st_r;
  cfl_ld_state_type st_nxt;
  cfl_bus_req_type bus;
  cfl_port_fields_type port_f [4];
  logic fire;
  logic take;
  logic [3:0] ld_link;
  logic [3:0] ld_pmcap;
  logic [3:0] ld_pmdata;
  logic [1:0] rd_port;
  logic [7:0] rd_off;
  logic [31:0] cfg_word;

  assign bus = '{addr: bus_addr_in, wdata: bus_wdata_in, wr: bus_wr_in, rd: bus_rd_in};

  // word index to memory address, in fixed load order
  function automatic logic [7:0] word_addr(input logic [2:0] i);
    case (i)
      3'h0: word_addr = CFL_WADDR_P0_LINK;
      3'h1: word_addr = CFL_WADDR_P1_LINK;
      3'h2: word_addr = CFL_WADDR_P2_LINK;
      3'h3: word_addr = CFL_WADDR_P3_LINK;
      3'h4: word_addr = CFL_WADDR_P0_PMCAP;
      3'h5: word_addr = CFL_WADDR_P0_PMDATA;
      3'h6: word_addr = CFL_WADDR_P1_PMCAP;
      default: word_addr = CFL_WADDR_P1_PMDATA;
    endcase
  endfunction : word_addr

  // a present word loads; an absent one leaves the fields as they were
  assign fire = (st_r.state == ST_WAIT) && mem_rsp_in.valid;
  assign take = fire && !mem_rsp_in.absent;

  // load strobes per port, decoded from the word index
  always_comb
  begin
    ld_link = '0;
    ld_pmcap = '0;
    ld_pmdata = '0;
    if (take)
    begin
      if (!st_r.idx[2])
        ld_link[st_r.idx[1:0]] = 1'b1;
      else if (!st_r.idx[0])
        ld_pmcap[{1'b0, st_r.idx[1]}] = 1'b1;
      else
        ld_pmdata[{1'b0, st_r.idx[1]}] = 1'b1;
    end
  end

  // one field store per port; only ports 0 and 1 take power words here
  for (genvar p = 0; p < 4; p++)
  begin : g_port
    cfl_port_fields #(
      .PM_EN(p < 2)
    ) u_fields (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .load_link_in(ld_link[p]),
      .load_pmcap_in(ld_pmcap[p]),
      .load_pmdata_in(ld_pmdata[p]),
      .word_in(mem_rsp_in.data),
      .fields_out(port_f[p])
    );
  end

  assign rd_port = bus.addr[9:8];
  assign rd_off = bus.addr[7:0];

  // configuration dword view; bits not loaded here read as zero
  always_comb
  begin
    cfg_word = '0;
    case (rd_off)
      CFL_OFF_PMCAP:
      begin
        cfg_word[CFL_C_AUX_LSB +: 3] = port_f[rd_port].aux_current;
        cfg_word[CFL_C_D1_BIT] = port_f[rd_port].d1_support;
        cfg_word[CFL_C_D2_BIT] = port_f[rd_port].d2_support;
        cfg_word[CFL_C_PME_LSB +: 2] = port_f[rd_port].pme_support;
      end
      CFL_OFF_PMCSR:
      begin
        cfg_word[CFL_C_NOSR_BIT] = port_f[rd_port].no_soft_reset;
        cfg_word[CFL_C_PMDATA_LSB +: 8] = port_f[rd_port].pm_data;
      end
      CFL_OFF_LINKCTL: cfg_word[CFL_C_COMPL_BIT] = port_f[rd_port].compl_det;
      CFL_OFF_PHY2: cfg_word[CFL_C_PHY2_LSB +: 5] = port_f[rd_port].phy2;
      CFL_OFF_MACCTL: cfg_word[CFL_C_DCC_LSB +: 2] = port_f[rd_port].dcc_sel;
      CFL_OFF_PHY3: cfg_word[CFL_C_PHY3_LSB +: 7] = port_f[rd_port].phy3;
      CFL_OFF_DEEMPH: cfg_word[CFL_C_DEEMPH_BIT] = port_f[rd_port].deemph;
      default: cfg_word = '0;
    endcase
  end

  // sequencer and register port; all software-visible config is read-only
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.req = 1'b0;
    st_nxt.rdata = '0;
    unique case (st_r.state)
      ST_IDLE:
      begin
        if (st_r.reload_pend)
        begin
          st_nxt.reload_pend = 1'b0;
          st_nxt.done = 1'b0;
          st_nxt.idx = '0;
          st_nxt.loaded_cnt = '0;
          st_nxt.absent_cnt = '0;
          st_nxt.state = ST_ISSUE;
        end
      end
      ST_ISSUE:
      begin
        st_nxt.req = 1'b1;
        st_nxt.addr = word_addr(st_r.idx);
        st_nxt.state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (fire)
        begin
          if (mem_rsp_in.absent)
            st_nxt.absent_cnt = st_r.absent_cnt + 4'h1;
          else
            st_nxt.loaded_cnt = st_r.loaded_cnt + 4'h1;
          if (st_r.idx == LAST_IDX)
          begin
            st_nxt.done = 1'b1;
            st_nxt.state = ST_IDLE;
          end
          else
          begin
            st_nxt.idx = st_r.idx + 3'h1;
            st_nxt.state = ST_ISSUE;
          end
        end
      end
    endcase
    // reload request after the sequencer, so a new write beats the idle clear
    if (bus.wr && bus.addr[10] && (rd_off == CFL_OFF_CTRL) && bus.wdata[CFL_CTRL_RELOAD_BIT])
      st_nxt.reload_pend = 1'b1;
    // config reads are held off as zero until the whole map is in
    if (bus.rd)
    begin
      if (bus.addr[10])
      begin
        if (rd_off == CFL_OFF_STATUS)
        begin
          st_nxt.rdata[CFL_STAT_DONE_BIT] = st_r.done;
          st_nxt.rdata[CFL_STAT_BUSY_BIT] = (st_r.state != ST_IDLE);
          st_nxt.rdata[CFL_STAT_LOADED_LSB +: 4] = st_r.loaded_cnt;
          st_nxt.rdata[CFL_STAT_ABSENT_LSB +: 4] = st_r.absent_cnt;
        end
      end
      else if (st_r.done)
        st_nxt.rdata = cfg_word;
    end
  end

  // loading starts on its own as reset releases
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      st_r <= '{state: ST_ISSUE, idx: 3'h0, req: 1'b0, addr: 8'h00, done: 1'b0,
                reload_pend: 1'b0, loaded_cnt: 4'h0, absent_cnt: 4'h0, rdata: 32'h0000_0000};
    else
      st_r <= st_nxt;
  end

  assign bus_rdata_out = st_r.rdata;
  assign mem_req_out = st_r.req;
  assign mem_addr_out = st_r.addr;
  assign load_done_out = st_r.done;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  a_port0_phy2_load:
    assert property (take && st_r.idx == 3'h0 |=> port_f[0].phy2 == $past(mem_rsp_in.data[4:0]))
      else $error("port 0 phy parameter 2 not loaded");
  a_port0_dcc_load:
    assert property (take && st_r.idx == 3'h0 |=> port_f[0].dcc_sel == $past(mem_rsp_in.data[15:14]))
      else $error("port 0 data count select not loaded");
  a_port1_phy2_read:
    assert property (bus.rd && !bus.addr[10] && rd_port == 2'h1 && rd_off == CFL_OFF_PHY2 && st_r.done
      |=> bus_rdata_out[12:8] == $past(port_f[1].phy2))
      else $error("port 1 phy parameter 2 read wrong");
  a_port1_phy3_load:
    assert property (take && st_r.idx == 3'h1 |=> port_f[1].phy3 == $past(mem_rsp_in.data[11:5]))
      else $error("port 1 phy parameter 3 not loaded");
  a_port1_deemph_load:
    assert property (take && st_r.idx == 3'h1 |=> port_f[1].deemph == $past(mem_rsp_in.data[12]))
      else $error("port 1 de-emphasis not loaded");
  a_port1_compl_load:
    assert property (take && st_r.idx == 3'h1 |=> port_f[1].compl_det == $past(mem_rsp_in.data[13]))
      else $error("port 1 compliance to detect not loaded");
  a_port2_link_load:
    assert property (take && st_r.idx == 3'h2 |=> {port_f[2].dcc_sel, port_f[2].compl_det,
      port_f[2].deemph, port_f[2].phy3, port_f[2].phy2} == $past(mem_rsp_in.data))
      else $error("port 2 link word not loaded");
  a_port3_dcc_load:
    assert property (take && st_r.idx == 3'h3 |=> port_f[3].dcc_sel == $past(mem_rsp_in.data[15:14]))
      else $error("port 3 data count select not loaded");
  a_port0_pmcap_load:
    assert property (take && st_r.idx == 3'h4 |=> port_f[0].no_soft_reset == $past(mem_rsp_in.data[0])
      && port_f[0].aux_current == $past(mem_rsp_in.data[3:1]))
      else $error("port 0 capability word not loaded");
  a_dstate_read:
    assert property (bus.rd && !bus.addr[10] && rd_off == CFL_OFF_PMCAP && st_r.done
      |=> bus_rdata_out[26:25] == $past({port_f[rd_port].d2_support, port_f[rd_port].d1_support}))
      else $error("power state support bits read wrong");
  a_dstate_readonly:
    assert property (bus.wr && !bus.addr[10] && st_r.state == ST_IDLE
      |=> $stable(port_f[0]) && $stable(port_f[1]))
      else $error("config write changed a loaded field");
  a_pme_load:
    assert property (take && st_r.idx == 3'h4 |=> port_f[0].pme_support == $past(mem_rsp_in.data[7:6]))
      else $error("pme support not loaded");
  a_pmdata_load:
    assert property (take && st_r.idx == 3'h5 |=> port_f[0].pm_data == $past(mem_rsp_in.data[15:8]))
      else $error("port 0 power data not loaded");
  a_port1_pm_load:
    assert property (take && st_r.idx == 3'h6 |=> port_f[1].pme_support == $past(mem_rsp_in.data[7:6])
      && port_f[1].d1_support == $past(mem_rsp_in.data[4]))
      else $error("port 1 capability word not loaded");
  a_busy_reads_zero:
    assert property (bus.rd && !bus.addr[10] && !st_r.done |=> bus_rdata_out == 32'h0000_0000)
      else $error("config read served before load done");
  a_absent_keeps:
    assert property (fire && mem_rsp_in.absent && st_r.idx == 3'h0 |=> $stable(port_f[0]))
      else $error("absent word changed fields");
  a_req_then_wait:
    assert property (mem_req_out |-> st_r.state == ST_WAIT ##1 !mem_req_out)
      else $error("request longer than one cycle");

  c_load_done: cover property ($rose(load_done_out));
  c_absent_word: cover property (fire && mem_rsp_in.absent);
  c_reload: cover property (st_r.reload_pend ##1 st_r.state == ST_ISSUE);
  c_cfg_read: cover property (bus.rd && !bus.addr[10] && st_r.done);

endmodule : cfl_config_loader

`default_nettype wire

/* File: sim/cfl_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cfl_mem_model (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic mem_req_in,
  input wire logic [7:0] mem_addr_in,
  input wire logic [3:0] delay_in,
  output var cfl_pkg::cfl_mem_rsp_type mem_rsp_out
);
  import cfl_pkg::*;

  logic [15:0] word_mem [0:255];
  logic absent_mem [0:255];
  logic [7:0] addr_q;

  // one word outstanding; a reset drops it so no stale answer reaches the loader
  initial
  begin
    mem_rsp_out = '0;
    forever
    begin
      @(posedge clk_sys_in);
      if (reset_n_in && mem_req_in)
      begin
        addr_q = mem_addr_in;
        for (int i = 0; i < delay_in && reset_n_in; i++)
          @(posedge clk_sys_in);
        if (reset_n_in)
        begin
          mem_rsp_out <= '{1'b1, absent_mem[addr_q], word_mem[addr_q]};
          @(posedge clk_sys_in);
        end
        // idle data flips so a late sample never matches by luck
        mem_rsp_out <= '{1'b0, 1'b0, ~mem_rsp_out.data};
      end
    end
  end
endmodule : cfl_mem_model

`default_nettype wire

/* File: sim/tb_eeprom_config_field_loader.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_eeprom_config_field_loader;
  import cfl_pkg::*;

  localparam logic [7:0] WADDR [8] = '{CFL_WADDR_P0_LINK, CFL_WADDR_P1_LINK, CFL_WADDR_P2_LINK, CFL_WADDR_P3_LINK,
    CFL_WADDR_P0_PMCAP, CFL_WADDR_P0_PMDATA, CFL_WADDR_P1_PMCAP, CFL_WADDR_P1_PMDATA};
  localparam logic [7:0] OFFS [7] = '{8'h40, 8'h44, 8'h78, 8'h7C, 8'h8C, 8'h90, 8'hF0};

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [10:0] bus_addr = '0;
  logic [31:0] bus_wdata = '0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic mem_req;
  logic [7:0] mem_addr;
  cfl_mem_rsp_type mem_rsp;
  logic load_done;
  logic [3:0] delay_v = 4'h0;
  logic [15:0] hold [8];
  logic [7:0] addr_log [$];
  logic [31:0] rd_v;
  int num_errors = 0;
  int samples_checked = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  cfl_config_loader dut_u (
    .clk_sys_in(clk_sys),
    .reset_n_in(reset_n),
    .bus_addr_in(bus_addr),
    .bus_wdata_in(bus_wdata),
    .bus_wr_in(bus_wr),
    .bus_rd_in(bus_rd),
    .bus_rdata_out(bus_rdata),
    .mem_req_out(mem_req),
    .mem_addr_out(mem_addr),
    .mem_rsp_in(mem_rsp),
    .load_done_out(load_done)
  );

  cfl_mem_model mem_u (
    .clk_sys_in(clk_sys),
    .reset_n_in(reset_n),
    .mem_req_in(mem_req),
    .mem_addr_in(mem_addr),
    .delay_in(delay_v),
    .mem_rsp_out(mem_rsp)
  );

  // word requests in the order the loader issues them
  always @(posedge clk_sys)
    if (mem_req === 1'b1)
      addr_log.push_back(mem_addr);

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check32

  // strobes are launched just after an edge; read data sampled mid-cycle
  task automatic bus_read(input logic [10:0] a, output logic [31:0] d);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(negedge clk_sys);
    d = bus_rdata;
    @(posedge clk_sys);
  endtask : bus_read

  task automatic bus_write(input logic [10:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask : bus_write

  // absent words leave the held copy untouched
  task automatic set_words(input logic [15:0] base, input logic [7:0] absent);
    for (int i = 0; i < 8; i++)
    begin
      mem_u.word_mem[WADDR[i]] = base ^ (16'h2B6D * i[15:0]);
      mem_u.absent_mem[WADDR[i]] = absent[i];
      if (!absent[i])
        hold[i] = mem_u.word_mem[WADDR[i]];
    end
  endtask : set_words

  function automatic logic [31:0] exp_dword(input int p, input logic [7:0] off);
    logic [15:0] l;
    logic [15:0] c;
    logic [15:0] d;
    l = hold[p];
    c = (p < 2) ? hold[4 + 2 * p] : 16'h0000;
    d = (p < 2) ? hold[5 + 2 * p] : 16'h0000;
    case (off)
      8'h40: return {2'h0, c[7:6], 1'b0, c[5], c[4], c[3:1], 22'h0};
      8'h44: return {d[15:8], 20'h0, c[0], 3'h0};
      8'h78: return {20'h0, l[13], 11'h0};
      8'h7C: return {19'h0, l[4:0], 8'h00};
      8'h8C: return {22'h0, l[15:14], 8'h00};
      8'h90: return {25'h0, l[11:5]};
      8'hF0: return {25'h0, l[12], 6'h00};
      default: return 32'h0;
    endcase
  endfunction : exp_dword

  task automatic wait_done;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clk_sys);
      if (load_done === 1'b1)
        break;
    end
    @(posedge clk_sys);
    check32("load_done", 32'h1, {31'h0, load_done});
  endtask : wait_done

  task automatic check_ports;
    for (int p = 0; p < 4; p++)
      foreach (OFFS[k])
      begin
        bus_read({1'b0, p[1:0], OFFS[k]}, rd_v);
        check32("config dword", exp_dword(p, OFFS[k]), rd_v);
      end
  endtask : check_ports

  task automatic check_order;
    check32("request count", 32'd8, addr_log.size());
    foreach (addr_log[i])
      if (i < 8)
        check32("request addr", {24'h0, WADDR[i]}, {24'h0, addr_log[i]});
    addr_log = {};
  endtask : check_order

  // only done, busy and the two counters are defined in status
  task automatic check_status(input logic [3:0] loaded, input logic [3:0] absent);
    bus_read({1'b1, 2'b00, CFL_OFF_STATUS}, rd_v);
    check32("status", {16'h0, absent, loaded, 8'h01}, rd_v & 32'h0000FF03);
  endtask : check_status

  task automatic test_initial_load;
    bus_read({1'b0, 2'd1, CFL_OFF_PHY2}, rd_v);
    check32("early config read", 32'h0, rd_v);
    wait_done();
    check_order();
    check_ports();
    check_status(4'd8, 4'd0);
    $display("test_initial_load done");
  endtask : test_initial_load

  task automatic test_bus_edges;
    bus_write({1'b0, 2'd1, CFL_OFF_PHY2}, 32'hFFFFFFFF);
    bus_read({1'b0, 2'd1, CFL_OFF_PHY2}, rd_v);
    check32("read-only phy2", exp_dword(1, 8'h7C), rd_v);
    bus_write({1'b0, 2'd0, CFL_OFF_PMCAP}, 32'hFFFFFFFF);
    bus_read({1'b0, 2'd0, CFL_OFF_PMCAP}, rd_v);
    check32("read-only pmcap", exp_dword(0, 8'h40), rd_v);
    bus_read({1'b0, 2'd2, 8'h7D}, rd_v);
    check32("unaligned read", 32'h0, rd_v);
    bus_read({1'b0, 2'd3, 8'h10}, rd_v);
    check32("unmapped read", 32'h0, rd_v);
    $display("test_bus_edges done");
  endtask : test_bus_edges

  task automatic test_reload_absent;
    delay_v <= 4'h3;
    set_words(16'h5A3C, 8'b1000_0100);
    bus_write({1'b1, 2'b00, CFL_OFF_CTRL}, 32'h1);
    // done only drops one edge after the reload write is taken
    @(posedge clk_sys);
    bus_read({1'b0, 2'd0, CFL_OFF_PHY2}, rd_v);
    check32("read while loading", 32'h0, rd_v);
    wait_done();
    check_order();
    check_ports();
    check_status(4'd6, 4'd2);
    $display("test_reload_absent done");
  endtask : test_reload_absent

  task automatic test_reset_all_absent;
    delay_v <= 4'h2;
    set_words(16'hFFFF, 8'hFF);
    bus_write({1'b1, 2'b00, CFL_OFF_CTRL}, 32'h1);
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    addr_log = {};
    foreach (hold[i])
      hold[i] = 16'h0000;
    reset_n <= 1'b1;
    @(posedge clk_sys);
    wait_done();
    check_order();
    check_ports();
    check_status(4'd0, 4'd8);
    $display("test_reset_all_absent done");
  endtask : test_reset_all_absent

  // watchdog: all tests need well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("MISMATCH watchdog expected finish seen hang");
    test_done();
  end

  initial
  begin
    #1;
    set_words(16'hC3A5, 8'h00);
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    test_initial_load();
    test_bus_edges();
    test_reload_absent();
    test_reset_all_absent();
    test_done();
  end
endmodule : tb_eeprom_config_field_loader

`default_nettype wire
